// [nes_pkg.sv]
// Shared constants and types of the NAND ECC status and parity readout block
package nes_pkg;

  // Register byte addresses
  localparam logic [31:0] OFS_LOC    = 32'hffffe80c;
  localparam logic [31:0] OFS_CHK    = 32'h0fffe810;
  localparam logic [31:0] OFS_UFLAGS = 32'hffffe814;
  localparam logic [31:0] OFS_CTRL   = 32'hffffe830;
  localparam logic [31:0] OFS_ISTAT  = 32'hffffe834;
  localparam logic [31:0] OFS_IMASK  = 32'hffffe838;
  localparam logic [31:0] OFS_SPAR0  = 32'hffffe840;

  // Upper sector window: sectors 8..15, 256 bytes each
  localparam int          SEC_FIRST  = 8;
  localparam int          SEC_LOG    = 8;
  localparam logic [11:0] UPPER_BYTE = 12'h800;

  // Flag nibble positions
  localparam int FLG_REC = 0;
  localparam int FLG_CHK = 1;
  localparam int FLG_MUL = 2;

  // Location register fields
  localparam int LOC_BIT_LSB  = 0;
  localparam int LOC_WORD_LSB = 4;

  // Interrupt event bits
  localparam int IRQ_SINGLE = 0;
  localparam int IRQ_MULTI  = 1;
  localparam int IRQ_CHKB   = 2;
  localparam int IRQ_PARITY = 3;

  // Reset values
  localparam logic [1:0]  RST_GRAN  = 2'h0;
  localparam logic [3:0]  RST_IRQ   = 4'h0;
  localparam logic [31:0] RST_WORD  = 32'h0;

  // Correction granularity codes
  typedef enum logic [1:0] {
    GRAN_PAGE = 2'b00,
    GRAN_256  = 2'b01,
    GRAN_512  = 2'b10,
    GRAN_RSV  = 2'b11
  } nes_gran_t;

  // Register bus request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } nes_bus_t;

  // Per-sector check result from the ECC engine
  typedef struct packed {
    logic [11:0] first_byte;
    logic        any_err;
    logic        chk_err;
    logic        multi;
    logic [23:0] syndrome;
  } nes_sec_res_t;

  // Whole-page check result from the ECC engine
  typedef struct packed {
    logic        single;
    logic        multi;
    logic [3:0]  bit_pos;
    logic [11:0] word_pos;
  } nes_page_res_t;

endpackage

// [nes_readout.sv]
// Status, location and parity readout registers of the NAND ECC unit
`timescale 1ns/1ps
module nes_readout
  import nes_pkg::*;
#(
  parameter int NSEC = 8
) (
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire nes_bus_t      bus,
  output logic [31:0]        rdata,
  input  wire logic          page_start,
  input  wire logic          sec_valid,
  input  wire nes_sec_res_t  sec_res,
  input  wire logic          page_valid,
  input  wire nes_page_res_t page_res,
  input  wire logic          par_valid,
  input  wire logic [15:0]   par_bits,
  output nes_gran_t          gran,
  output logic               irq
);

  // Map a sector's first byte to its upper-window slot
  function automatic logic [2:0] slot_of(input logic [11:0] b);
    slot_of = b[SEC_LOG+2:SEC_LOG];
  endfunction

  // True when a byte address falls in the upper window
  function automatic logic in_upper(input logic [11:0] b);
    in_upper = (b >= UPPER_BYTE);
  endfunction

  nes_gran_t     gran_ff;
  logic [NSEC-1:0] rec_ff;
  logic [NSEC-1:0] chk_ff;
  logic [NSEC-1:0] mul_ff;
  logic [23:0]   spar_ff [NSEC];
  logic [3:0]    bitpos_ff;
  logic [11:0]   wordpos_ff;
  logic [15:0]   ncheck_ff;
  logic [3:0]    istat_ff;
  logic [3:0]    imask_ff;
  logic [31:0]   rdata_ff;
  logic          irq_ff;

  logic          wr_ctrl;
  logic          wr_istat;
  logic          wr_imask;
  logic          sec_take;
  logic [2:0]    sec_slot;
  logic          sec_chk;
  logic [3:0]    ev;
  logic [31:0]   nxt_rdata;
  logic [31:0]   uflags;
  logic [2:0]    rd_slot;
  logic          rd_spar;

  assign gran  = gran_ff;
  assign irq   = irq_ff;
  assign rdata = rdata_ff;

  // Write decode
  assign wr_ctrl  = bus.wr && (bus.addr == OFS_CTRL);
  assign wr_istat = bus.wr && (bus.addr == OFS_ISTAT);
  assign wr_imask = bus.wr && (bus.addr == OFS_IMASK);

  // Sector result acceptance
  assign sec_slot = slot_of(sec_res.first_byte);
  assign sec_take = sec_valid && (gran_ff == GRAN_256)
                    && in_upper(sec_res.first_byte);
  assign sec_chk  = sec_res.chk_err && !sec_res.multi;

  // Granularity control register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gran_ff <= nes_gran_t'(RST_GRAN);
    end else if (wr_ctrl && bus.wdata[1:0] != GRAN_RSV) begin
      gran_ff <= nes_gran_t'(bus.wdata[1:0]);
    end
  end

  // Per-sector flags, cleared at page start; a result wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rec_ff <= '0;
      chk_ff <= '0;
      mul_ff <= '0;
    end else begin
      for (int i = 0; i < NSEC; i++) begin
        if (sec_take && sec_slot == 3'(i)) begin
          rec_ff[i] <= sec_res.any_err;
          chk_ff[i] <= sec_chk;
          mul_ff[i] <= sec_res.multi;
        end else if (page_start) begin
          rec_ff[i] <= 1'b0;
          chk_ff[i] <= 1'b0;
          mul_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Sector parity position capture
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NSEC; i++) begin
        spar_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NSEC; i++) begin
        if (sec_take && sec_chk && sec_slot == 3'(i)) begin
          spar_ff[i] <= sec_res.syndrome;
        end
      end
    end
  end

  // Whole-page error location, kept only on a single error
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bitpos_ff  <= '0;
      wordpos_ff <= '0;
    end else if (page_valid && page_res.single
                 && !page_res.multi && gran_ff == GRAN_PAGE) begin
      bitpos_ff  <= page_res.bit_pos;
      wordpos_ff <= page_res.word_pos;
    end
  end

  // Inverted check word, held for the host to copy out
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ncheck_ff <= '0;
    end else if (par_valid) begin
      ncheck_ff <= par_bits;
    end
  end

  // Interrupt events
  always_comb begin
    ev = '0;
    ev[IRQ_SINGLE] = (sec_take && sec_res.any_err && !sec_res.multi)
                     || (page_valid && page_res.single);
    ev[IRQ_MULTI]  = (sec_take && sec_res.multi)
                     || (page_valid && page_res.multi);
    ev[IRQ_CHKB]   = sec_take && sec_chk;
    ev[IRQ_PARITY] = par_valid;
  end

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      istat_ff <= RST_IRQ;
    end else begin
      istat_ff <= (istat_ff & ~(wr_istat ? bus.wdata[3:0] : 4'h0)) | ev;
    end
  end

  // Interrupt mask
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      imask_ff <= RST_IRQ;
    end else if (wr_imask) begin
      imask_ff <= bus.wdata[3:0];
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(((istat_ff & ~(wr_istat ? bus.wdata[3:0] : 4'h0)) | ev)
                  & (wr_imask ? bus.wdata[3:0] : imask_ff));
    end
  end

  // Upper status word packing, zero in whole-page mode
  always_comb begin
    uflags = '0;
    for (int i = 0; i < NSEC; i++) begin
      uflags[4*i+FLG_REC] = rec_ff[i];
      uflags[4*i+FLG_CHK] = chk_ff[i];
      uflags[4*i+FLG_MUL] = mul_ff[i];
    end
    if (gran_ff == GRAN_PAGE) begin
      uflags = '0;
    end
  end

  // Read decode
  assign rd_slot = bus.addr[4:2];
  assign rd_spar = (bus.addr[31:5] == OFS_SPAR0[31:5])
                   && (bus.addr[1:0] == 2'b00);

  always_comb begin
    nxt_rdata = '0;
    if (bus.rd) begin
      if (bus.addr == OFS_LOC) begin
        nxt_rdata[LOC_BIT_LSB+:4]   = bitpos_ff;
        nxt_rdata[LOC_WORD_LSB+:12] = wordpos_ff;
      end else if (bus.addr == OFS_CHK) begin
        nxt_rdata[15:0] = ncheck_ff;
      end else if (bus.addr == OFS_UFLAGS) begin
        nxt_rdata = uflags;
      end else if (bus.addr == OFS_CTRL) begin
        nxt_rdata[1:0] = gran_ff;
      end else if (bus.addr == OFS_ISTAT) begin
        nxt_rdata[3:0] = istat_ff;
      end else if (bus.addr == OFS_IMASK) begin
        nxt_rdata[3:0] = imask_ff;
      end else if (rd_spar) begin
        nxt_rdata[23:0] = spar_ff[rd_slot];
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= RST_WORD;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Checks
  property p_page_zero;
    @(posedge core_clk) disable iff (reset)
    (bus.rd && bus.addr == OFS_UFLAGS && gran_ff == GRAN_PAGE)
      |=> (rdata == 32'h0);
  endproperty
  a_page_zero: assert property (p_page_zero)
    else $error("Upper flags not zero in whole-page mode");

  property p_rec_set;
    @(posedge core_clk) disable iff (reset)
    (sec_take && sec_res.any_err)
      |=> rec_ff[$past(sec_slot)];
  endproperty
  a_rec_set: assert property (p_rec_set)
    else $error("Recoverable flag not set after an error");

  property p_chk_set;
    @(posedge core_clk) disable iff (reset)
    (sec_take && sec_res.chk_err && !sec_res.multi)
      |=> chk_ff[$past(sec_slot)];
  endproperty
  a_chk_set: assert property (p_chk_set)
    else $error("Check-byte flag not set");

  property p_spar_cap;
    @(posedge core_clk) disable iff (reset)
    (sec_take && sec_chk)
      |=> (spar_ff[$past(sec_slot)] == $past(sec_res.syndrome));
  endproperty
  a_spar_cap: assert property (p_spar_cap)
    else $error("Sector parity position not captured");

  property p_mul_flag;
    @(posedge core_clk) disable iff (reset)
    sec_take |=> (mul_ff[$past(sec_slot)] == $past(sec_res.multi));
  endproperty
  a_mul_flag: assert property (p_mul_flag)
    else $error("Multi-error flag wrong");

  property p_window;
    @(posedge core_clk) disable iff (reset)
    (sec_valid && sec_res.first_byte < UPPER_BYTE)
      |=> $stable(rec_ff) or $fell(|rec_ff) or (rec_ff == '0);
  endproperty
  a_window: assert property (p_window)
    else $error("Sector outside upper window recorded");

  property p_nibble;
    @(posedge core_clk) disable iff (reset)
    (bus.rd && bus.addr == OFS_UFLAGS)
      |=> (rdata & 32'h88888888) == 32'h0;
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("Reserved nibble bit set");

  property p_loc;
    @(posedge core_clk) disable iff (reset)
    (page_valid && page_res.single && !page_res.multi
     && gran_ff == GRAN_PAGE)
      |=> (bitpos_ff == $past(page_res.bit_pos))
          && (wordpos_ff == $past(page_res.word_pos));
  endproperty
  a_loc: assert property (p_loc)
    else $error("Page location not captured");

  // A multiple-error page leaves the last good location in place
  property p_loc_hold;
    @(posedge core_clk) disable iff (reset)
    (page_valid && page_res.multi)
      |=> $stable(bitpos_ff) && $stable(wordpos_ff);
  endproperty
  a_loc_hold: assert property (p_loc_hold)
    else $error("Location changed on a multiple-error page");

  // Location readout packs the word above the bit offset
  property p_loc_read;
    @(posedge core_clk) disable iff (reset)
    (bus.rd && bus.addr == OFS_LOC)
      |=> (rdata == {16'h0, $past(wordpos_ff), $past(bitpos_ff)});
  endproperty
  a_loc_read: assert property (p_loc_read)
    else $error("Page location readout wrong");

  property p_chk_word;
    @(posedge core_clk) disable iff (reset)
    (bus.rd && bus.addr == OFS_CHK)
      |=> (rdata[31:16] == 16'h0) && (rdata[15:0] == $past(ncheck_ff));
  endproperty
  a_chk_word: assert property (p_chk_word)
    else $error("Check word readout wrong");

  property p_gran_hold;
    @(posedge core_clk) disable iff (reset)
    (wr_ctrl && bus.wdata[1:0] == 2'b11) |=> $stable(gran_ff);
  endproperty
  a_gran_hold: assert property (p_gran_hold)
    else $error("Reserved granularity accepted");

  // The level output tracks the masked status in every cycle
  property p_irq;
    @(posedge core_clk) disable iff (reset)
    irq == (|(istat_ff & imask_ff));
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt level disagrees with masked status");

endmodule

// [nes_engine_model.sv]
// Behavioural ECC engine model feeding check results to the readout block
`timescale 1ns/1ps
module nes_engine_model
  import nes_pkg::*;
(
  input  wire logic core_clk,
  output logic          page_start,
  output logic          sec_valid,
  output nes_sec_res_t  sec_res,
  output logic          page_valid,
  output nes_page_res_t page_res,
  output logic          par_valid,
  output logic [15:0]   par_bits
);
  // Idle outputs from time zero
  initial begin
    page_start = 1'b0;
    sec_valid  = 1'b0;
    sec_res    = '0;
    page_valid = 1'b0;
    page_res   = '0;
    par_valid  = 1'b0;
    par_bits   = 16'h0;
  end

  // Sector result pulse; payload scrambled after the strobe so stale data never matches
  task automatic send_sec(input logic [11:0] fb, input logic [2:0] f, input logic [23:0] syn);
    @(posedge core_clk);
    sec_valid <= 1'b1;
    sec_res   <= '{fb, f[0], f[1], f[2], syn};
    @(posedge core_clk);
    sec_valid <= 1'b0;
    sec_res   <= nes_sec_res_t'(~sec_res);
  endtask

  // Whole-page result pulse
  task automatic send_page(input logic s, input logic m, input logic [3:0] b,
                           input logic [11:0] w);
    @(posedge core_clk);
    page_valid <= 1'b1;
    page_res   <= '{s, m, b, w};
    @(posedge core_clk);
    page_valid <= 1'b0;
    page_res   <= nes_page_res_t'(~page_res);
  endtask

  // New inverted check word after a page write
  task automatic send_par(input logic [15:0] p);
    @(posedge core_clk);
    par_valid <= 1'b1;
    par_bits  <= p;
    @(posedge core_clk);
    par_valid <= 1'b0;
    par_bits  <= ~par_bits;
  endtask

  // Start of a new page read
  task automatic pulse_start;
    @(posedge core_clk);
    page_start <= 1'b1;
    @(posedge core_clk);
    page_start <= 1'b0;
  endtask
endmodule

// [nand_ecc_status_and_parity_readout_tb_top.sv]
// Self-checking testbench of the NAND ECC status and parity readout block
`timescale 1ns/1ps
module nand_ecc_status_and_parity_readout_tb_top;
  import nes_pkg::*;
  logic          core_clk = 1'b0;
  logic          reset = 1'b1;
  nes_bus_t      bus = '0;
  logic [31:0]   rdata;
  logic          page_start;
  logic          sec_valid;
  nes_sec_res_t  sec_res;
  logic          page_valid;
  nes_page_res_t page_res;
  logic          par_valid;
  logic [15:0]   par_bits;
  nes_gran_t     gran;
  logic          irq;
  int            bad_count = 0;
  int            total_checks = 0;
  int            cycles = 0;
  logic [31:0]   ef;
  logic [1:0]    ge;
  logic [2:0]    f;
  int            k;

  // Clock at 4 ns
  always #2 core_clk = ~core_clk;

  nes_readout dut (.core_clk(core_clk), .reset(reset), .bus(bus), .rdata(rdata),
    .page_start(page_start), .sec_valid(sec_valid), .sec_res(sec_res),
    .page_valid(page_valid), .page_res(page_res), .par_valid(par_valid),
    .par_bits(par_bits), .gran(gran), .irq(irq));

  nes_engine_model eng (.core_clk(core_clk), .page_start(page_start), .sec_valid(sec_valid),
    .sec_res(sec_res), .page_valid(page_valid), .page_res(page_res),
    .par_valid(par_valid), .par_bits(par_bits));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read strobe one cycle, data sampled in the following cycle
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(OFS_LOC, RST_WORD);
    rd_chk(OFS_CHK, RST_WORD);
    rd_chk(OFS_UFLAGS, RST_WORD);
    bus_wr(32'hffffe800, 32'hffffffff);
    rd_chk(32'hffffe800, 32'h0);
    chk({30'h0, gran}, {30'h0, GRAN_PAGE});
    $display("test reset done");
    ge = 2'h0;
    for (int i = 1; i < 6; i++) begin
      bus_wr(OFS_CTRL, 32'(i % 4));
      if (i % 4 != 3) ge = 2'(i % 4);
      chk({30'h0, gran}, {30'h0, ge});
    end
    $display("test granularity done");
    ef = '0;
    for (int n = 0; n < 8; n++) begin
      k = n % 3;
      f = (k == 0) ? 3'b001 : (k == 1) ? 3'b011 : 3'b111;
      eng.send_sec(12'h800 + 12'(n) * 12'h100, f, 24'h1 << (3 * n));
      ef[4*n +: 4] = (k == 0) ? 4'h1 : (k == 1) ? 4'h3 : 4'h5;
    end
    eng.send_sec(12'h7ff, 3'b111, 24'h1);
    rd_chk(OFS_UFLAGS, ef);
    for (int n = 1; n < 8; n += 3) begin
      rd_chk(OFS_SPAR0 + 32'(4 * n), 32'h1 << (3 * n));
    end
    bus_wr(OFS_CTRL, 32'h0);
    rd_chk(OFS_UFLAGS, 32'h0);
    bus_wr(OFS_CTRL, 32'h1);
    rd_chk(OFS_UFLAGS, ef);
    eng.pulse_start();
    bus_wr(OFS_CTRL, 32'h2);
    eng.send_sec(12'h900, 3'b001, 24'h0);
    rd_chk(OFS_UFLAGS, 32'h0);
    $display("test sectors done");
    bus_wr(OFS_CTRL, 32'h0);
    eng.send_page(1'b1, 1'b0, 4'h5, 12'habc);
    rd_chk(OFS_LOC, 32'h0000abc5);
    eng.send_page(1'b1, 1'b0, 4'hf, 12'hfff);
    rd_chk(OFS_LOC, 32'h0000ffff);
    eng.send_page(1'b0, 1'b1, 4'h2, 12'h123);
    rd_chk(OFS_LOC, 32'h0000ffff);
    eng.send_page(1'b1, 1'b0, 4'h0, 12'h000);
    rd_chk(OFS_LOC, 32'h0);
    eng.send_par(16'h1234);
    rd_chk(OFS_CHK, 32'h00001234);
    $display("test page done");
    rd_chk(OFS_ISTAT, 32'hf);
    bus_wr(OFS_ISTAT, 32'hf);
    rd_chk(OFS_ISTAT, 32'h0);
    eng.send_par(16'hffff);
    rd_chk(OFS_ISTAT, 32'h8);
    chk({31'h0, irq}, 32'h0);
    bus_wr(OFS_IMASK, 32'h8);
    chk({31'h0, irq}, 32'h1);
    bus_wr(OFS_ISTAT, 32'h8);
    chk({31'h0, irq}, 32'h0);
    bus_wr(OFS_IMASK, 32'h2);
    bus_wr(OFS_CTRL, 32'h1);
    eng.send_sec(12'ha00, 3'b101, 24'h0);
    #1;
    chk({31'h0, irq}, 32'h1);
    rd_chk(OFS_ISTAT, 32'h2);
    $display("test interrupts done");
    report_and_stop();
  end
endmodule
